// ---- rtl/sit_switch_cfg.sv ----
`timescale 1ns/1ps
// Behaviour
// - Masked-off input never raises interrupt
// - Enabled input change in Normal raises interrupt
// - Masks writable any time in Normal
// - All enable bits reset to one
// - Programmable mask at 0x0d, bits 7-0
// - Ground mask at 0x0e, bits 13-0
// - Sleep config at 0x0f, wake/poll fields
// - Wake timer expiry leaves sleep, interrupts
// - Wake select zero disables timer wake
// - Wake select code to interval table
// - Wake select resets to zero
// - Polling event every poll period in sleep
// - Poll currents on for fixed windows
// - Poll select table, reset 1111
module sit_switch_cfg
	import sit_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   srst,
	// Serial port pins
	input  wire logic                   sclk,
	input  wire logic                   cs_n,
	input  wire logic                   mosi,
	output logic                        miso,
	output logic                        miso_oe,
	// Switch inputs and status pins
	input  wire logic [PROG_INPUTS-1:0] programmable_inputs,
	input  wire logic [GND_INPUTS-1:0]  ground_switch_inputs,
	input  wire logic                   fault_in,
	input  wire logic                   sleep_req,
	// Outputs
	output logic                        irq_n,
	output logic                        irq_pending_flag,
	output logic                        sleep_state,
	output logic                        poll_gnd_on,
	output logic                        poll_prog_on
);

	if (MS_CYC < 2 || MS_CYC > (1 << 24) - 1)
		$error("MS_CYC out of range");

	typedef struct packed {
		logic                  sclk_s1, sclk_s2, sclk_d;
		logic                  csn_s1, csn_s2, csn_d;
		logic                  mosi_s1, mosi_s2;
		logic                  flt_s1, flt_s2;
		logic                  slp_s1, slp_s2, slp_d;
		logic [ALL_INPUTS-1:0] sw_s1, sw_s2, sw_d;
		logic [31:0]           sh_in;
		logic [31:0]           sh_out;
		logic [5:0]            bits;
		logic                  miso;
		logic [6:0]            last_addr;
		logic [7:0]            prog_mask;
		logic [13:0]           gnd_mask;
		logic [7:0]            cfg;
		logic                  flag;
		logic                  sleep;
		logic [23:0]           ms_cnt;
		logic                  ms_tick;
		logic [ON_W-1:0]       gnd_cnt;
		logic [ON_W-1:0]       prog_cnt;
		logic                  gnd_on;
		logic                  prog_on;
	} sit_state_t;

	sit_state_t st;
	sit_state_t next_st;
	logic       poll_evt;
	logic       wake_evt;

	function automatic logic [RSP_DATA_W-1:0] reg_data(input sit_state_t s, input logic [6:0] a);
		case (a)
			ADDR_PROG_MASK: reg_data = {14'h0000, s.prog_mask};
			ADDR_GND_MASK:  reg_data = {8'h00, s.gnd_mask};
			ADDR_SLEEP_CFG: reg_data = {14'h0000, s.cfg};
			default:        reg_data = 22'h000000;
		endcase
	endfunction

	sit_ms_timer u_poll (
		.mclk      (mclk),
		.srst      (srst),
		.run       (st.sleep),
		.ms_tick   (st.ms_tick),
		.period_ms (poll_ms(st.cfg[POLL_SEL_MSB:POLL_SEL_LSB])),
		.expire    (poll_evt)
	);

	sit_ms_timer u_wake (
		.mclk      (mclk),
		.srst      (srst),
		.run       (st.sleep && st.cfg[WAKE_SEL_MSB:WAKE_SEL_LSB] != WAKE_OFF),
		.ms_tick   (st.ms_tick),
		.period_ms (wake_ms(st.cfg[WAKE_SEL_MSB:WAKE_SEL_LSB])),
		.expire    (wake_evt)
	);

	always_comb
	begin
		logic                  sclk_rise;
		logic                  sclk_fall;
		logic                  csn_fall;
		logic                  csn_rise;
		logic                  irq_evt;
		logic [ALL_INPUTS-1:0] chg;
		logic [6:0]            addr;
		logic [23:0]           wdata;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		csn_fall  = 1'b0;
		csn_rise  = 1'b0;
		irq_evt   = 1'b0;
		chg       = '0;
		addr      = '0;
		wdata     = '0;
		next_st = st;

		// Pin synchronisers
		next_st.sclk_s1 = sclk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d  = st.sclk_s2;
		next_st.csn_s1  = cs_n;
		next_st.csn_s2  = st.csn_s1;
		next_st.csn_d   = st.csn_s2;
		next_st.mosi_s1 = mosi;
		next_st.mosi_s2 = st.mosi_s1;
		next_st.flt_s1  = fault_in;
		next_st.flt_s2  = st.flt_s1;
		next_st.slp_s1  = sleep_req;
		next_st.slp_s2  = st.slp_s1;
		next_st.slp_d   = st.slp_s2;
		next_st.sw_s1   = {ground_switch_inputs, programmable_inputs};
		next_st.sw_s2   = st.sw_s1;
		next_st.sw_d    = st.sw_s2;

		sclk_rise = st.sclk_s2 && !st.sclk_d;
		sclk_fall = !st.sclk_s2 && st.sclk_d;
		csn_fall  = !st.csn_s2 && st.csn_d;
		csn_rise  = st.csn_s2 && !st.csn_d;

		// Millisecond prescaler shared by both timers
		next_st.ms_tick = 1'b0;
		if (st.ms_cnt == 24'(MS_CYC - 1))
		begin
			next_st.ms_cnt  = '0;
			next_st.ms_tick = 1'b1;
		end
		else
			next_st.ms_cnt = st.ms_cnt + 24'd1;

		// Serial shifter, sample on rising and shift on falling clock edge
		if (csn_fall)
		begin
			next_st.bits   = '0;
			next_st.sh_out = {st.last_addr, 1'b0, st.flt_s2, st.flag,
				reg_data(st, st.last_addr)};
			next_st.miso   = st.last_addr[6];
			// Any host access brings the device back to Normal mode
			next_st.sleep  = 1'b0;
		end
		else if (!st.csn_s2)
		begin
			if (sclk_rise)
			begin
				next_st.sh_in = {st.sh_in[30:0], st.mosi_s2};
				if (st.bits != 6'(FRAME_BITS))
					next_st.bits = st.bits + 6'd1;
			end
			if (sclk_fall)
			begin
				next_st.sh_out = {st.sh_out[30:0], 1'b0};
				next_st.miso   = st.sh_out[30];
			end
		end

		// Frames shorter than 32 bits are dropped whole; longer ones keep their last 32 bits
		if (csn_rise && st.bits == 6'(FRAME_BITS))
		begin
			addr  = st.sh_in[ADDR_MSB:ADDR_LSB];
			wdata = st.sh_in[23:0];
			next_st.last_addr = addr;
			next_st.flag      = 1'b0;
			if (st.sh_in[RW_BIT])
			begin
				case (addr)
					ADDR_PROG_MASK: next_st.prog_mask = wdata[7:0];
					ADDR_GND_MASK:  next_st.gnd_mask = wdata[13:0];
					ADDR_SLEEP_CFG: next_st.cfg = wdata[7:0];
					default: ;
				endcase
			end
		end

		// Change detection only in Normal mode
		chg     = st.sw_s2 ^ st.sw_d;
		irq_evt = !st.sleep && |(chg & {st.gnd_mask, st.prog_mask});

		if (st.slp_s2 && !st.slp_d && st.csn_s2)
		begin
			next_st.sleep = 1'b1;
			// Restart the prescaler so the first timed event is a full period after entry
			if (!st.sleep)
			begin
				next_st.ms_cnt  = '0;
				next_st.ms_tick = 1'b0;
			end
		end

		if (wake_evt && st.sleep)
		begin
			next_st.sleep = 1'b0;
			irq_evt = 1'b1;
		end

		// Set wins over a clear in the same cycle
		if (irq_evt)
			next_st.flag = 1'b1;

		// Polling current windows
		if (poll_evt && st.sleep)
		begin
			next_st.gnd_cnt  = ON_W'(GND_ON_CYC);
			next_st.prog_cnt = ON_W'(PROG_ON_CYC);
			next_st.gnd_on   = 1'b1;
			next_st.prog_on  = 1'b1;
		end
		else
		begin
			if (st.gnd_cnt != '0)
				next_st.gnd_cnt = st.gnd_cnt - ON_W'(1);
			if (st.prog_cnt != '0)
				next_st.prog_cnt = st.prog_cnt - ON_W'(1);
			next_st.gnd_on  = st.gnd_cnt > ON_W'(1);
			next_st.prog_on = st.prog_cnt > ON_W'(1);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			st           <= '0;
			st.sclk_d    <= 1'b0;
			st.csn_s1    <= 1'b1;
			st.csn_s2    <= 1'b1;
			st.csn_d     <= 1'b1;
			st.prog_mask <= PROG_MASK_RST;
			st.gnd_mask  <= GND_MASK_RST;
			st.cfg       <= SLEEP_CFG_RST;
		end
		else
			st <= next_st;
	end

	assign miso             = st.miso;
	assign miso_oe          = !st.csn_s2;
	assign irq_n            = !st.flag;
	assign irq_pending_flag = st.flag;
	assign sleep_state      = st.sleep;
	assign poll_gnd_on      = st.gnd_on;
	assign poll_prog_on     = st.prog_on;

endmodule

// ---- rtl/sit_pkg.sv ----
package sit_pkg;

	// Frame layout
	localparam int FRAME_BITS   = 32;
	localparam int ADDR_MSB     = 31;
	localparam int ADDR_LSB     = 25;
	localparam int RW_BIT       = 24;
	localparam int RSP_FAULT    = 23;
	localparam int RSP_FLAG     = 22;
	localparam int RSP_DATA_W   = 22;

	// Register addresses
	localparam logic [6:0] ADDR_PROG_MASK = 7'h0d;
	localparam logic [6:0] ADDR_GND_MASK  = 7'h0e;
	localparam logic [6:0] ADDR_SLEEP_CFG = 7'h0f;

	// Widths and reset values
	localparam int PROG_INPUTS = 8;
	localparam int GND_INPUTS  = 14;
	localparam int ALL_INPUTS  = PROG_INPUTS + GND_INPUTS;
	localparam logic [7:0]  PROG_MASK_RST = 8'hff;
	localparam logic [13:0] GND_MASK_RST  = 14'h3fff;
	localparam logic [7:0]  SLEEP_CFG_RST = 8'h0f;

	// Config fields
	localparam int WAKE_SEL_MSB = 7;
	localparam int WAKE_SEL_LSB = 4;
	localparam int POLL_SEL_MSB = 3;
	localparam int POLL_SEL_LSB = 0;
	localparam logic [3:0] WAKE_OFF = 4'h0;

	// Timing
	localparam int CLK_HZ      = 20_000_000;
	localparam int MS_CYCLES   = CLK_HZ / 1000;
	localparam int GND_ON_US   = 64;
	localparam int PROG_ON_US  = 128;
	localparam int GND_ON_CYC  = (GND_ON_US * (CLK_HZ / 1_000_000) > 0) ?
		GND_ON_US * (CLK_HZ / 1_000_000) : 1;
	localparam int PROG_ON_CYC = (PROG_ON_US * (CLK_HZ / 1_000_000) > 0) ?
		PROG_ON_US * (CLK_HZ / 1_000_000) : 1;
	localparam int MS_W        = 10;
	localparam int ON_W        = 16;

	function automatic logic [MS_W-1:0] wake_ms(input logic [3:0] sel);
		case (sel)
			4'h1: wake_ms = 10'd6;
			4'h2: wake_ms = 10'd12;
			4'h3: wake_ms = 10'd24;
			4'h4: wake_ms = 10'd48;
			4'h5: wake_ms = 10'd96;
			4'h6: wake_ms = 10'd192;
			4'h7: wake_ms = 10'd394;
			4'h8: wake_ms = 10'd4;
			4'h9: wake_ms = 10'd8;
			4'ha: wake_ms = 10'd16;
			4'hb: wake_ms = 10'd32;
			4'hc: wake_ms = 10'd64;
			4'hd: wake_ms = 10'd128;
			4'he: wake_ms = 10'd256;
			4'hf: wake_ms = 10'd512;
			default: wake_ms = 10'd0;
		endcase
	endfunction

	function automatic logic [MS_W-1:0] poll_ms(input logic [3:0] sel);
		case (sel)
			4'h0: poll_ms = 10'd3;
			4'h1: poll_ms = 10'd6;
			4'h2: poll_ms = 10'd12;
			4'h3: poll_ms = 10'd24;
			4'h4: poll_ms = 10'd48;
			4'h5: poll_ms = 10'd68;
			4'h6: poll_ms = 10'd76;
			4'h7: poll_ms = 10'd128;
			4'h8: poll_ms = 10'd32;
			4'h9: poll_ms = 10'd36;
			4'ha: poll_ms = 10'd40;
			4'hb: poll_ms = 10'd44;
			4'hc: poll_ms = 10'd52;
			4'hd: poll_ms = 10'd56;
			4'he: poll_ms = 10'd60;
			default: poll_ms = 10'd64;
		endcase
	endfunction

endpackage

// ---- rtl/sit_ms_timer.sv ----
`timescale 1ns/1ps
module sit_ms_timer
	import sit_pkg::*;
(
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            srst,
	// Control
	input  wire logic            run,
	input  wire logic            ms_tick,
	input  wire logic [MS_W-1:0] period_ms,
	// Event
	output logic                 expire
);

	typedef struct packed {
		logic [MS_W-1:0] cnt;
		logic            expire;
	} sit_tmr_t;

	sit_tmr_t st;
	sit_tmr_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.expire = 1'b0;
		if (!run)
			next_st.cnt = '0;
		else if (ms_tick)
		begin
			// Period change takes effect at the next ms tick, checked against the running count
			if (st.cnt + 10'd1 >= period_ms)
			begin
				next_st.cnt = '0;
				next_st.expire = 1'b1;
			end
			else
				next_st.cnt = st.cnt + 10'd1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign expire = st.expire;

endmodule

// ---- bench/sit_switch_cfg_checker.sv ----
`timescale 1ns/1ps
module sit_switch_cfg_checker
	import sit_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	// Clock and reset
	input wire logic                   mclk,
	input wire logic                   srst,
	// Watched ports
	input wire logic                   cs_n,
	input wire logic                   miso_oe,
	input wire logic [PROG_INPUTS-1:0] programmable_inputs,
	input wire logic [GND_INPUTS-1:0]  ground_switch_inputs,
	input wire logic                   irq_n,
	input wire logic                   irq_pending_flag,
	input wire logic                   sleep_state,
	input wire logic                   poll_gnd_on,
	input wire logic                   poll_prog_on
);
	logic [ALL_INPUTS-1:0] seen;
	logic [7:0]            quiet;
	logic [7:0]            idle;
	logic [11:0]           gl;
	logic [11:0]           pl;

	// Ages saturate so a long quiet spell never wraps into a false cause
	always_ff @(posedge mclk)
	begin
		seen <= {programmable_inputs, ground_switch_inputs};
		if (srst || seen != {programmable_inputs, ground_switch_inputs})
			quiet <= 8'h00;
		else if (quiet != 8'hff)
			quiet <= quiet + 8'h01;
		if (srst || !cs_n)
			idle <= 8'h00;
		else if (idle != 8'hff)
			idle <= idle + 8'h01;
		gl <= poll_gnd_on ? gl + 12'h001 : 12'h000;
		pl <= poll_prog_on ? pl + 12'h001 : 12'h000;
	end

	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (srst);

	chk_irq_pin: assert property (irq_n == !irq_pending_flag)
		else $error("interrupt pin disagrees with flag");
	chk_oe_frame: assert property (!cs_n [*7] |-> miso_oe)
		else $error("reply driver off in frame");
	chk_oe_idle: assert property (cs_n [*7] |-> !miso_oe)
		else $error("reply driver on between frames");
	chk_gnd_window: assert property ($fell(poll_gnd_on) && sleep_state |-> gl == GND_ON_CYC)
		else $error("ground poll window length");
	chk_prog_window: assert property ($fell(poll_prog_on) && sleep_state |-> pl == PROG_ON_CYC)
		else $error("programmable poll window length");
	chk_first_poll: assert property ($rose(sleep_state) |-> !poll_gnd_on [*8])
		else $error("poll event too soon after sleep entry");
	chk_irq_cause: assert property ($rose(irq_pending_flag) && !$past(sleep_state) |-> quiet < 8'h08)
		else $error("interrupt without input change");
	chk_wake_cause: assert property ($fell(sleep_state) |-> irq_pending_flag || idle < 8'h08)
		else $error("sleep left without cause");

	cov_wake: cover property ($fell(sleep_state) && irq_pending_flag);
	cov_poll: cover property ($fell(poll_gnd_on));
	cov_irq: cover property ($rose(irq_pending_flag) && !sleep_state);
endmodule

bind sit_switch_cfg sit_switch_cfg_checker #(.MS_CYC(MS_CYC)) CHK
(
	.mclk, .srst, .cs_n, .miso_oe, .programmable_inputs, .ground_switch_inputs,
	.irq_n, .irq_pending_flag, .sleep_state, .poll_gnd_on, .poll_prog_on
);

// ---- bench/sit_host.sv ----
`timescale 1ns/1ps
module sit_host
(
	// Clock
	input  wire logic mclk,
	// Serial pins
	output logic      sclk = 1'h0,
	output logic      cs_n = 1'h1,
	output logic      mosi = 1'h0,
	input  wire logic miso
);
	// Phases of 4 mclk give a 400 ns serial clock; n below 32 sends a short frame
	task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
		r = 32'h0;
		@(posedge mclk);
		cs_n <= 1'h0;
		repeat (8) @(posedge mclk);
		for (int i = 0; i < n; i++)
		begin
			mosi <= w[31-i];
			repeat (4) @(posedge mclk);
			sclk <= 1'h1;
			repeat (4) @(posedge mclk);
			r = {r[30:0], miso};
			sclk <= 1'h0;
		end
		repeat (8) @(posedge mclk);
		cs_n <= 1'h1;
		mosi <= ~mosi;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// ---- bench/sit_switch_cfg_tb.sv ----
`timescale 1ns/1ps
module sit_switch_cfg_tb;
	import sit_pkg::*;
	localparam int MSC = 900;
	logic        mclk = 1'h0;
	logic        srst = 1'h1;
	logic        fault_in = 1'h0;
	logic        sleep_req = 1'h0;
	logic [7:0]  programmable_inputs = 8'h00;
	logic [13:0] ground_switch_inputs = 14'h0000;
	wire         sclk, cs_n, mosi, miso, miso_oe, irq_n, irq_pending_flag;
	wire         sleep_state, poll_gnd_on, poll_prog_on;
	wire [3:0]   mon = {poll_gnd_on, sleep_state, irq_pending_flag, irq_n};
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;

	sit_switch_cfg #(.MS_CYC(MSC)) DUT
	(
		.mclk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe, .programmable_inputs,
		.ground_switch_inputs, .fault_in, .sleep_req, .irq_n, .irq_pending_flag,
		.sleep_state, .poll_gnd_on, .poll_prog_on
	);
	sit_host HOST (.mclk, .sclk, .cs_n, .mosi, .miso);

	always #25 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			$display("[ERR] %0t run hung", $time);
			err_total++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] ex(logic [6:0] a, logic [1:0] st, logic [21:0] d);
		return {a, 1'h0, st, d};
	endfunction

	task automatic acc(logic [6:0] a, logic w, logic [23:0] d, logic [31:0] e);
		logic [31:0] r;
		HOST.xfer({a, w, d}, 32, r);
		chk(r, e);
	endtask

	task automatic wait_for(input int s, input logic v, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (mon[s] !== v && n < lim);
	endtask

	task automatic sleep_now;
		int n;
		sleep_req <= 1'h1;
		wait_for(2, 1'h1, 20, n);
		@(posedge mclk);
		sleep_req <= 1'h0;
	endtask

	task automatic t_regs;
		logic [31:0] r;
		logic [7:0]  p;
		logic [7:0]  v;
		HOST.xfer({ADDR_PROG_MASK, 25'h0}, 32, r);
		acc(ADDR_GND_MASK, 1'h0, 24'h0, ex(7'h0d, 2'h0, 22'h0000ff));
		acc(ADDR_SLEEP_CFG, 1'h0, 24'h0, ex(7'h0e, 2'h0, 22'h003fff));
		acc(7'h30, 1'h1, 24'hffffff, ex(7'h0f, 2'h0, 22'h00000f));
		acc(7'h0d, 1'h1, 24'hffff5a, ex(7'h30, 2'h0, 22'h0));
		acc(7'h0e, 1'h1, 24'hffffff, ex(7'h0d, 2'h0, 22'h5a));
		HOST.xfer({7'h0e, 1'h1, 24'h0}, 16, r);
		acc(7'h0f, 1'h0, 24'h0, ex(7'h0e, 2'h0, 22'h3fff));
		p = 8'h0f;
		for (int c = 0; c < 16; c++)
		begin
			v = {4'(c), ~4'(c)};
			acc(7'h0f, 1'h1, {16'hffff, v}, ex(7'h0f, 2'h0, {14'h0, p}));
			p = v;
		end
	endtask

	task automatic t_irq;
		acc(7'h0d, 1'h1, 24'h01, ex(7'h0f, 2'h0, 22'hf0));
		acc(7'h0e, 1'h1, 24'h0, ex(7'h0d, 2'h0, 22'h01));
		programmable_inputs <= 8'h02;
		ground_switch_inputs <= 14'h2001;
		repeat (12) @(posedge mclk);
		#1;
		chk(irq_n, 1'h1);
		programmable_inputs <= 8'h03;
		fault_in <= 1'h1;
		repeat (6) @(posedge mclk);
		#1;
		chk(irq_n, 1'h0);
		acc(7'h0d, 1'h0, 24'h0, ex(7'h0e, 2'h3, 22'h0));
		fault_in <= 1'h0;
		chk(irq_pending_flag, 1'h0);
	endtask

	task automatic t_poll;
		int n;
		int m;
		acc(7'h0f, 1'h1, 24'h0, ex(7'h0d, 2'h0, 22'h01));
		sleep_now();
		wait_for(3, 1'h1, 5*MSC, n);
		chk(n > 3*MSC-8 && n < 4*MSC+8, 1'h1);
		chk(poll_prog_on, 1'h1);
		wait_for(3, 1'h0, 5*MSC, n);
		wait_for(3, 1'h1, 5*MSC, m);
		chk(n + m, 3*MSC);
		wait_for(2, 1'h0, 5*MSC, n);
		chk(n, 5*MSC);
	endtask

	task automatic t_wake;
		int          n;
		logic [31:0] r;
		for (int k = 0; k < 2; k++)
		begin
			HOST.xfer({7'h0f, 1'h1, 16'h0, k ? 8'h17 : 8'h87}, 32, r);
			sleep_now();
			wait_for(2, 1'h0, 8*MSC, n);
			chk(n > (k ? 6 : 4)*MSC-8 && n < (k ? 7 : 5)*MSC+8, 1'h1);
			chk(irq_pending_flag, 1'h1);
		end
	endtask

	initial
	begin
		repeat (6) @(posedge mclk);
		srst <= 1'h0;
		repeat (2) @(posedge mclk);
		t_regs();
		t_irq();
		t_poll();
		t_wake();
		end_of_test();
	end
endmodule
